// File: hdl/periodic_tick_timer.sv
// Periodic tick timer: period counter, register port and period-end interrupt.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "periodic_tick_timer_defines.svh"

module periodic_tick_timer
    import periodic_tick_timer_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PTT_TICK_CYCLES
)(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire reg_req_s    bus_req,
    output logic [31:0]      rd_data,
    output logic             period_end_irq,
    output logic             period_end_pulse
);

    // ************************************************************************
    // Declarations
    // ************************************************************************
    ctrl_s       ctrl_q;
    logic [7:0]  period_q;
    logic [7:0]  count_q;
    logic [1:0]  status_q;
    logic [1:0]  status_d;
    logic [1:0]  mask_q;
    logic [15:0] ticks_q;
    logic [31:0] rd_data_q;
    logic        irq_q;
    logic        pulse_q;
    logic        tick;
    logic        wr_ctrl;
    logic        wr_period;
    logic        wr_status;
    logic        wr_mask;
    logic        restart;
    logic        expire;
    logic        step;
    logic [1:0]  st_set;
    logic [1:0]  st_clr;

    // ************************************************************************
    // Tick source
    // ************************************************************************
    tick_clock_source #(
        .TICK_CYCLES (TICK_CYCLES)
    ) tick_clock_source_inst (
        .ref_clk (ref_clk),
        .reset   (reset),
        .sync_en (ctrl_q.sync_en),
        .tick    (tick)
    );

    // ************************************************************************
    // Register writes
    // ************************************************************************
    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `PTT_CTRL_OFS);
    assign wr_period = bus_req.wr && (bus_req.addr == `PTT_PERIOD_OFS);
    assign wr_status = bus_req.wr && (bus_req.addr == `PTT_STATUS_OFS);
    assign wr_mask   = bus_req.wr && (bus_req.addr == `PTT_MASK_OFS);
    assign restart   = wr_ctrl && bus_req.wdata[`PTT_CTRL_RESTART_BIT];

    // The reset is synchronous and only expected at power-on; the timer then runs on its own.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ctrl_q <= ctrl_s'(`PTT_CTRL_RST);
        else if (wr_ctrl)
        begin
            ctrl_q.run     <= bus_req.wdata[`PTT_CTRL_RUN_BIT];
            ctrl_q.sync_en <= bus_req.wdata[`PTT_CTRL_SYNC_BIT];
        end
    end

    // A new period takes effect at the next reload, so a running period is never cut short.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            period_q <= `PTT_PERIOD_RST;
        else if (wr_period)
            period_q <= bus_req.wdata[7:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            mask_q <= `PTT_MASK_RST;
        else if (wr_mask)
            mask_q <= bus_req.wdata[1:0];
    end

    // ************************************************************************
    // Period counter
    // ************************************************************************
    assign step   = ctrl_q.run && tick;
    assign expire = step && (count_q == 8'h00) && !restart;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            count_q <= `PTT_PERIOD_RST - 8'h01;
        else if (restart)
            count_q <= period_q - 8'h01;
        else if (expire)
            count_q <= period_q - 8'h01;
        else if (step)
            count_q <= count_q - 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ticks_q <= 16'h0000;
        else if (expire)
            ticks_q <= ticks_q + 16'h0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pulse_q <= 1'b0;
        else
            pulse_q <= expire;
    end

    // ************************************************************************
    // Status and interrupt
    // ************************************************************************
    // A second expiry before firmware cleared the first is a lost tick for software counts.
    always_comb
    begin
        st_clr = wr_status ? bus_req.wdata[1:0] : 2'h0;
        st_set = 2'h0;
        st_set[`PTT_ST_END_BIT]  = expire;
        st_set[`PTT_ST_MISS_BIT] = expire && status_q[`PTT_ST_END_BIT]
                                   && !st_clr[`PTT_ST_END_BIT];
        status_d = (status_q & ~st_clr) | st_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            status_q <= 2'h0;
        else
            status_q <= status_d;
    end

    // Registered from the next status so the line rises in the cycle after the expiry.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_d & mask_q);
    end

    // ************************************************************************
    // Register reads
    // ************************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rd_data_q <= 32'h00000000;
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                `PTT_CTRL_OFS:   rd_data_q <= {30'h0, ctrl_q.sync_en, ctrl_q.run};
                `PTT_PERIOD_OFS: rd_data_q <= {24'h0, period_q};
                `PTT_COUNT_OFS:  rd_data_q <= {24'h0, count_q};
                `PTT_STATUS_OFS: rd_data_q <= {30'h0, status_q};
                `PTT_MASK_OFS:   rd_data_q <= {30'h0, mask_q};
                `PTT_TICKS_OFS:  rd_data_q <= {16'h0, ticks_q};
                default:         rd_data_q <= 32'h00000000;
            endcase
        end
        else
            rd_data_q <= 32'h00000000;
    end

    assign rd_data          = rd_data_q;
    assign period_end_irq   = irq_q;
    assign period_end_pulse = pulse_q;

    // ************************************************************************
    // Assertions
    // ************************************************************************
    sequence s_expire;
        ctrl_q.run && tick && (count_q == 8'h00) && !restart;
    endsequence

    sequence s_step;
        ctrl_q.run && tick && (count_q != 8'h00) && !restart;
    endsequence

    property p_expire_flag;
        @(posedge ref_clk) disable iff (reset)
        s_expire |=> status_q[`PTT_ST_END_BIT] && period_end_pulse;
    endproperty
    a_expire_flag: assert property (p_expire_flag)
        else $error("expiry did not set the period-end flag");

    property p_irq_follows;
        @(posedge ref_clk) disable iff (reset)
        s_expire ##0 mask_q[`PTT_ST_END_BIT] && !wr_mask |=> period_end_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("unmasked expiry did not raise the interrupt");

    property p_irq_quiet;
        @(posedge ref_clk) disable iff (reset)
        !(|((status_q | st_set) & mask_q)) |=> !period_end_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt high with no unmasked flag");

    property p_reload;
        @(posedge ref_clk) disable iff (reset)
        s_expire |=> count_q == $past(period_q) - 8'h01;
    endproperty
    a_reload: assert property (p_reload)
        else $error("period not reloaded after expiry");

    property p_count_step;
        @(posedge ref_clk) disable iff (reset)
        s_step |=> count_q == $past(count_q) - 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on tick");

    property p_only_at_zero;
        @(posedge ref_clk) disable iff (reset)
        period_end_pulse |-> $past(count_q) == 8'h00 && $past(tick);
    endproperty
    a_only_at_zero: assert property (p_only_at_zero)
        else $error("period end away from terminal count");

    property p_hold_no_tick;
        @(posedge ref_clk) disable iff (reset)
        !tick && !restart |=> $stable(count_q);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick)
        else $error("counter moved without a tick");

    property p_set_wins;
        @(posedge ref_clk) disable iff (reset)
        s_expire ##0 wr_status |=> status_q[`PTT_ST_END_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a same-cycle expiry");

    property p_pulse_single;
        @(posedge ref_clk) disable iff (reset)
        period_end_pulse |=> !period_end_pulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single)
        else $error("period-end pulse longer than one cycle");

    property p_restart_load;
        @(posedge ref_clk) disable iff (reset)
        restart |=> count_q == $past(period_q) - 8'h01;
    endproperty
    a_restart_load: assert property (p_restart_load)
        else $error("restart did not load the period");

    property p_freeze;
        @(posedge ref_clk) disable iff (reset)
        !ctrl_q.run && !restart |=> $stable(count_q) && !period_end_pulse;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("stopped timer moved or expired");

    property p_ticks_count;
        @(posedge ref_clk) disable iff (reset)
        s_expire |=> ticks_q == $past(ticks_q) + 16'h0001;
    endproperty
    a_ticks_count: assert property (p_ticks_count)
        else $error("expiry count did not advance");

    property p_clear_status;
        @(posedge ref_clk) disable iff (reset)
        wr_status && bus_req.wdata[`PTT_ST_END_BIT] && !expire |=> !status_q[`PTT_ST_END_BIT];
    endproperty
    a_clear_status: assert property (p_clear_status)
        else $error("write of one did not clear the period-end flag");

    property p_miss_flag;
        @(posedge ref_clk) disable iff (reset)
        s_expire ##0 status_q[`PTT_ST_END_BIT] && !(wr_status && bus_req.wdata[`PTT_ST_END_BIT])
            |=> status_q[`PTT_ST_MISS_BIT];
    endproperty
    a_miss_flag: assert property (p_miss_flag)
        else $error("expiry over a pending flag not marked as missed");

    property p_irq_on_flag;
        @(posedge ref_clk) disable iff (reset)
        (|(status_q & mask_q)) && !wr_status |=> period_end_irq;
    endproperty
    a_irq_on_flag: assert property (p_irq_on_flag)
        else $error("interrupt low while an unmasked flag is set");

    property p_no_early_end;
        @(posedge ref_clk) disable iff (reset)
        s_step |=> !period_end_pulse;
    endproperty
    a_no_early_end: assert property (p_no_early_end)
        else $error("period ended before the count ran out");

endmodule : periodic_tick_timer

// File: hdl/periodic_tick_timer_defines.svh
// Constants of the periodic tick timer: timing, register offsets, fields and reset values.
// Operation
// - The timer counts a tick of nominally 1 kHz, and that tick sets the rate of its output.
// - The tick is phase-aligned to the master clock, or is an unsynchronised divided clock.
// - Each expiry of the period raises the period-end interrupt towards the processor; the code needs mask bit 0 set, or bit 1 on a missed expiry.
// - The period is chosen so that the period-end interrupt comes once every 100 ms.
`ifndef PERIODIC_TICK_TIMER_DEFINES_SVH
`define PERIODIC_TICK_TIMER_DEFINES_SVH

// ****************************************************************************
// Timing
// ****************************************************************************
`define PTT_CLK_HZ         250000000
`define PTT_TICK_HZ        1000
`define PTT_TICK_CYCLES    (`PTT_CLK_HZ / `PTT_TICK_HZ)
`define PTT_PERIOD_MS      100
`define PTT_PERIOD_TICKS   (`PTT_PERIOD_MS * `PTT_TICK_HZ / 1000)

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define PTT_CTRL_OFS       8'h00
`define PTT_PERIOD_OFS     8'h04
`define PTT_COUNT_OFS      8'h08
`define PTT_STATUS_OFS     8'h0c
`define PTT_MASK_OFS       8'h10
`define PTT_TICKS_OFS      8'h14

// ****************************************************************************
// Fields and reset values
// ****************************************************************************
`define PTT_CTRL_RUN_BIT     0
`define PTT_CTRL_SYNC_BIT    1
`define PTT_CTRL_RESTART_BIT 2
`define PTT_ST_END_BIT       0
`define PTT_ST_MISS_BIT      1
`define PTT_CTRL_RST         2'h3
`define PTT_PERIOD_RST       8'h64
`define PTT_MASK_RST         2'h1

`endif

// File: hdl/periodic_tick_timer_pkg.sv
// Types shared by the periodic tick timer modules.
package periodic_tick_timer_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic sync_en;
        logic run;
    } ctrl_s;

endpackage : periodic_tick_timer_pkg

// File: hdl/tick_clock_source.sv
// Tick source: divides the master clock down to the 1 kHz timer tick.
`timescale 1ns/100ps
`include "periodic_tick_timer_defines.svh"

module tick_clock_source
    import periodic_tick_timer_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PTT_TICK_CYCLES
)(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic sync_en,
    output logic      tick
);

    logic [17:0] div_q;
    logic        slow_clk_q;
    logic        slow_clk_d1_q;
    logic        tick_q;
    logic        wrap;
    logic        half;

    assign wrap = (div_q == 18'(TICK_CYCLES - 1));
    assign half = (div_q == 18'(TICK_CYCLES / 2 - 1));

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            div_q <= 18'h00000;
        else if (wrap)
            div_q <= 18'h00000;
        else
            div_q <= div_q + 18'h00001;
    end

    // The divided clock is a real square wave so the unsynchronised mode sees its own edge.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            slow_clk_q <= 1'b0;
        else if (half)
            slow_clk_q <= 1'b1;
        else if (wrap)
            slow_clk_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            slow_clk_d1_q <= 1'b0;
        else
            slow_clk_d1_q <= slow_clk_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tick_q <= 1'b0;
        else if (sync_en)
            tick_q <= wrap;
        else
            tick_q <= slow_clk_q & ~slow_clk_d1_q;
    end

    assign tick = tick_q;

    // ************************************************************************
    // Assertions
    // ************************************************************************
    property p_sync_tick;
        @(posedge ref_clk) disable iff (reset)
        sync_en && wrap |=> tick;
    endproperty
    a_sync_tick: assert property (p_sync_tick)
        else $error("aligned tick missing after divider wrap");

    property p_unsync_tick;
        @(posedge ref_clk) disable iff (reset)
        !sync_en && $rose(slow_clk_q) |=> tick;
    endproperty
    a_unsync_tick: assert property (p_unsync_tick)
        else $error("divided clock edge gave no tick");

    property p_tick_single;
        @(posedge ref_clk) disable iff (reset)
        tick |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("tick longer than one cycle");

endmodule : tick_clock_source

// File: verif/isr_model.sv
// Firmware model: software timeout counter driven by the period-end event.
`timescale 1ns/100ps

module isr_model
    import periodic_tick_timer_pkg::*;
#(
    parameter int unsigned TIMEOUT_TICKS = 10
)(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic tick_evt,
    input  wire logic arm,
    output logic      fw_done
);
    logic [7:0] left_q;

    // Apart from the load on arm, the count moves only on a period-end event, as the handler would.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            left_q <= 8'h00;
        else if (arm)
            left_q <= 8'(TIMEOUT_TICKS);
        else if (tick_evt && left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end

    // Done is a level so a slow handler check still sees it.
    always_ff @(posedge ref_clk)
    begin
        if (reset || arm)
            fw_done <= 1'b0;
        else if (tick_evt && left_q == 8'h01)
            fw_done <= 1'b1;
    end
endmodule : isr_model

// File: verif/test_periodic_tick_timer.sv
// Testbench of the periodic tick timer with a firmware partner model.
`timescale 1ns/100ps

module test_periodic_tick_timer
    import periodic_tick_timer_pkg::*;
;
    localparam int TICK_CYC = 8;
    localparam int PER      = 100 * TICK_CYC;

    logic        ref_clk;
    logic        reset;
    reg_req_s    bus_req;
    logic [31:0] rd_data;
    logic        period_end_irq;
    logic        period_end_pulse;
    logic        arm;
    logic        fw_done;
    int          n_mismatch;
    int          check_count;
    int          n;
    int          total;
    logic [7:0]  ofs [7] = '{8'h08, 8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c};
    logic [31:0] rst [7] = '{32'h63, 32'h3, 32'h64, 32'h0, 32'h1, 32'h0, 32'h0};

    periodic_tick_timer #(.TICK_CYCLES(TICK_CYC)) periodic_tick_timer_inst (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .bus_req          (bus_req),
        .rd_data          (rd_data),
        .period_end_irq   (period_end_irq),
        .period_end_pulse (period_end_pulse)
    );

    isr_model isr_model_inst (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .tick_evt (period_end_pulse),
        .arm      (arm),
        .fw_done  (fw_done)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= reg_req_s'{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= reg_req_s'{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 chk(rd_data, exp);
    endtask : bus_rd

    // Bounded so that a timer that never expires cannot hang the run.
    task automatic wait_pulse(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        while (period_end_pulse !== 1'b1 && cyc < 20000);
        if (period_end_pulse !== 1'b1)
            n_mismatch++;
    endtask : wait_pulse

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #200000;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        reset = 1'b1;
        arm = 1'b0;
        bus_req = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
            bus_rd(ofs[i], rst[i]);
        // Two expiries without clearing also raise the missed flag.
        wait_pulse(n);
        chk(32'(period_end_irq), 32'h1);
        wait_pulse(n);
        chk(32'(n), 32'(PER));
        bus_rd(8'h0c, 32'h3);
        bus_rd(8'h14, 32'h2);
        bus_wr(8'h0c, 32'h3);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(period_end_irq), 32'h0);
        bus_wr(8'h10, 32'h0);
        wait_pulse(n);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(period_end_irq), 32'h0);
        bus_rd(8'h0c, 32'h1);
        bus_wr(8'h0c, 32'h1);
        bus_wr(8'h10, 32'h1);
        wait_pulse(n);
        @(posedge ref_clk);
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
        #1 total = 0;
        for (int i = 0; i < 10; i++)
        begin
            chk(32'(fw_done), 32'h0);
            wait_pulse(n);
            total += n;
        end
        @(posedge ref_clk);
        #1 chk(32'(fw_done), 32'h1);
        chk(32'(total + 2), 32'(10 * PER));
        bus_wr(8'h0c, 32'h3);
        bus_wr(8'h04, 32'h4);
        bus_wr(8'h00, 32'h7);
        wait_pulse(n);
        wait_pulse(n);
        chk(32'(n), 32'(4 * TICK_CYC));
        // The clear lands in the very cycle of the next expiry, so the flag must survive it.
        repeat (30) @(posedge ref_clk);
        bus_wr(8'h0c, 32'h3);
        bus_rd(8'h0c, 32'h1);
        bus_wr(8'h00, 32'h1);
        wait_pulse(n);
        wait_pulse(n);
        chk(32'(n), 32'(4 * TICK_CYC));
        bus_rd(8'h00, 32'h1);
        bus_wr(8'h00, 32'h6);
        repeat (64) @(posedge ref_clk);
        bus_rd(8'h08, 32'h3);
        complete_run();
    end
endmodule : test_periodic_tick_timer
